//--- rtl/analog_pin_digital_port.sv
// digital input/output logic for pins shared with the analog converter
// assumes pins arrive asynchronously; pad drives analog rails from pin_o/pin_oe_o
`timescale 1ns/1ps

// Function
// - Each pin is chosen on its own as analog input, digital input or digital output.
// - Data and input enable sit on the converter side, direction, output and level on the port side.
// - Each pin has its own enable bit that switches its digital input buffer.
// - A direction bit of 0 makes the pin an input whose read views depend on its enable.
// - An enabled input pin reads its present sampled level.
// - A disabled input pin always reads as one.
// - A direction bit of 1 drives the pin with the last written output value.
// - A driven zero means analog ground and a driven one means analog supply.
// - The level view equals the converter data view for enabled input pins.
// - Input, output and analog uses interleave freely across the port.
module analog_pin_digital_port #(
	parameter int PIN_COUNT = port_pkg::PIN_COUNT
) (
	input wire logic clk_i, // system clock, 40 MHz
	input wire logic nrst_i, // async reset, active low
	input wire logic dir_we_i, // write strobe, direction
	input wire logic out_we_i, // write strobe, output value
	input wire logic dien_we_i, // write strobe, input enable
	input wire logic [PIN_COUNT-1:0] wdata_i, // write data
	input wire logic [PIN_COUNT-1:0] pin_i, // pin levels
	output logic [PIN_COUNT-1:0] pin_o, // driven level, 1 = supply
	output logic [PIN_COUNT-1:0] pin_oe_o, // high while pin driven
	output logic [PIN_COUNT-1:0] buf_en_o, // digital input buffer enable
	output logic [PIN_COUNT-1:0] converter_port_data_o, // converter data view
	output logic [PIN_COUNT-1:0] port_output_value_o, // port value view
	output logic [PIN_COUNT-1:0] port_input_level_o, // port level view
	output logic [PIN_COUNT-1:0] port_direction_o, // direction readback
	output logic [PIN_COUNT-1:0] digital_input_enable_o // enable readback
);
	// carrier structs are sized by the package, so a different width cannot be served
	if (PIN_COUNT != port_pkg::PIN_COUNT)
	begin : g_bad_width
		$error("PIN_COUNT must match the package width");
	end

	port_pkg::port_cfg_t cfg;
	logic [PIN_COUNT-1:0] level_sync;
	port_pkg::port_rd_t rd_r;
	port_pkg::port_rd_t rd_nxt;
	logic [PIN_COUNT-1:0] drv_r;
	logic [PIN_COUNT-1:0] drv_nxt;
	logic [PIN_COUNT-1:0] oe_r;
	logic [PIN_COUNT-1:0] oe_nxt;
	logic [PIN_COUNT-1:0] ben_r;
	logic [PIN_COUNT-1:0] dir_rb_r;
	logic [PIN_COUNT-1:0] dien_rb_r;

	// software configuration; bit n is channel n throughout
	port_cfg_regs #(
		.WIDTH(PIN_COUNT)
	) u_cfg (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.dir_we_i(dir_we_i),
		.out_we_i(out_we_i),
		.dien_we_i(dien_we_i),
		.wdata_i(wdata_i),
		.cfg_o(cfg)
	);

	// pins are asynchronous, so two flops before any read view
	pin_sync #(
		.WIDTH(PIN_COUNT)
	) u_sync (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.async_i(pin_i),
		.sync_o(level_sync)
	);

	// per-pin view of one bit; shared by all three read paths
	function automatic logic read_bit(input logic dir, input logic dien,
		input logic lvl, input logic outv);
		if (dir == port_pkg::DIR_OUTPUT)
			read_bit = outv; // output reads back its written value
		else if (dien)
			read_bit = lvl;
		else
			read_bit = 1'h1;
	endfunction : read_bit

	// read views, computed independently per pin
	always_comb
	begin
		rd_nxt = rd_r;
		for (int n = 0; n < PIN_COUNT; n++)
		begin
			rd_nxt.conv_read[n] = read_bit(cfg.direction[n], cfg.dien[n],
				level_sync[n], cfg.out_value[n]);
			rd_nxt.out_read[n] = read_bit(cfg.direction[n], cfg.dien[n],
				level_sync[n], cfg.out_value[n]);
			rd_nxt.level_read[n] = read_bit(cfg.direction[n], cfg.dien[n],
				level_sync[n], cfg.out_value[n]);
		end
	end

	// pad drive: level 1 is analog supply, 0 analog ground
	always_comb
	begin
		drv_nxt = cfg.out_value;
		oe_nxt = cfg.direction;
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rd_r.conv_read <= port_pkg::ALL_ONES;
			rd_r.out_read <= port_pkg::ALL_ONES;
			rd_r.level_read <= port_pkg::ALL_ONES;
			drv_r <= port_pkg::OUT_RESET;
			oe_r <= port_pkg::DIR_RESET;
			ben_r <= port_pkg::DIEN_RESET;
			dir_rb_r <= port_pkg::DIR_RESET;
			dien_rb_r <= port_pkg::DIEN_RESET;
		end
		else
		begin
			rd_r <= rd_nxt;
			drv_r <= drv_nxt;
			oe_r <= oe_nxt;
			ben_r <= cfg.dien;
			dir_rb_r <= cfg.direction;
			dien_rb_r <= cfg.dien;
		end
	end

	// every output straight from a flop
	assign pin_o = drv_r;
	assign pin_oe_o = oe_r;
	assign buf_en_o = ben_r;
	assign converter_port_data_o = rd_r.conv_read;
	assign port_output_value_o = rd_r.out_read;
	assign port_input_level_o = rd_r.level_read;
	assign port_direction_o = dir_rb_r;
	assign digital_input_enable_o = dien_rb_r;
endmodule : analog_pin_digital_port

//--- rtl/pin_sync.sv
// two-flop synchroniser for the pin levels
// assumes pin levels are asynchronous to clk_i
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk_i, // system clock
	input wire logic nrst_i, // async reset, active low
	input wire logic [WIDTH-1:0] async_i, // raw pin levels
	output logic [WIDTH-1:0] sync_o // synchronised levels
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	// first stage feeds only the second
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			meta_r <= WIDTH'(0);
			sync_r <= WIDTH'(0);
		end
		else
		begin
			meta_r <= async_i;
			sync_r <= meta_r;
		end
	end

	assign sync_o = sync_r;
endmodule : pin_sync

//--- rtl/port_cfg_regs.sv
// per-pin configuration registers written by software
// assumes write strobes come from logic on clk_i
`timescale 1ns/1ps
module port_cfg_regs #(
	parameter int WIDTH = 8
) (
	input wire logic clk_i, // system clock
	input wire logic nrst_i, // async reset, active low
	input wire logic dir_we_i, // direction write strobe
	input wire logic out_we_i, // output value write strobe
	input wire logic dien_we_i, // input enable write strobe
	input wire logic [WIDTH-1:0] wdata_i, // write data
	output port_pkg::port_cfg_t cfg_o // registered configuration
);
	// struct fields are package-sized; write data must match them bit for bit
	if (WIDTH != port_pkg::PIN_COUNT)
	begin : g_bad_width
		$error("WIDTH must match the package width");
	end

	port_pkg::port_cfg_t cfg_r;
	port_pkg::port_cfg_t cfg_nxt;

	// each field keeps its value unless its strobe is high
	always_comb
	begin
		cfg_nxt = cfg_r;
		if (dir_we_i)
			cfg_nxt.direction = wdata_i;
		if (out_we_i)
			cfg_nxt.out_value = wdata_i;
		if (dien_we_i)
			cfg_nxt.dien = wdata_i;
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cfg_r.direction <= port_pkg::DIR_RESET;
			cfg_r.out_value <= port_pkg::OUT_RESET;
			cfg_r.dien <= port_pkg::DIEN_RESET;
		end
		else
			cfg_r <= cfg_nxt;
	end

	assign cfg_o = cfg_r;
endmodule : port_cfg_regs

//--- rtl/port_pkg.sv
// shared constants and carrier types for the analog-pin digital port
// assumes one clock domain; all users write port_pkg::name
package port_pkg;
	localparam int PIN_COUNT = 8;
	localparam logic [PIN_COUNT-1:0] DIR_RESET = 8'h00;
	localparam logic [PIN_COUNT-1:0] OUT_RESET = 8'h00;
	localparam logic [PIN_COUNT-1:0] DIEN_RESET = 8'h00;
	localparam logic [PIN_COUNT-1:0] SYNC_RESET = 8'h00;
	localparam logic [PIN_COUNT-1:0] ALL_ONES = 8'hFF;
	localparam logic DIR_INPUT = 1'h0;
	localparam logic DIR_OUTPUT = 1'h1;

	// software-side view of the port, one bit per channel
	typedef struct packed {
		logic [PIN_COUNT-1:0] direction;
		logic [PIN_COUNT-1:0] out_value;
		logic [PIN_COUNT-1:0] dien;
	} port_cfg_t;

	// the three read views of the port
	typedef struct packed {
		logic [PIN_COUNT-1:0] conv_read;
		logic [PIN_COUNT-1:0] out_read;
		logic [PIN_COUNT-1:0] level_read;
	} port_rd_t;
endpackage : port_pkg

//--- test/analog_pin_digital_port_test.sv
// self-checking bench for the analog-pin digital port
// assumes one 40 MHz clock and the far-side circuit model
`timescale 1ns/1ps
module analog_pin_digital_port_test;
	typedef struct packed {
		logic [7:0] view;
		logic [7:0] oe;
		logic [7:0] drv;
		logic [7:0] den;
	} exp_t;
	logic clk_i = 1'h0, nrst_i = 1'h0, chk = 1'h0;
	logic dir_we_i = 1'h0, out_we_i = 1'h0, dien_we_i = 1'h0;
	logic [7:0] wdata_i = 8'h00, drv = 8'h00, drv_en = 8'h00, dir, outv, den;
	logic [7:0] pin_i, pin_o, pin_oe_o, buf_en_o, cpd, pov, pil, pdir, pden;
	exp_t q[$];
	exp_t e, g;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	always #12.5 clk_i = ~clk_i;
	analog_pin_digital_port analog_pin_digital_port_inst (.clk_i(clk_i), .nrst_i(nrst_i),
		.dir_we_i(dir_we_i), .out_we_i(out_we_i), .dien_we_i(dien_we_i), .wdata_i(wdata_i),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .buf_en_o(buf_en_o),
		.converter_port_data_o(cpd), .port_output_value_o(pov), .port_input_level_o(pil),
		.port_direction_o(pdir), .digital_input_enable_o(pden));
	ext_circuit ext_circuit_inst (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
		.drv_i(drv), .drv_en_i(drv_en), .level_o(pin_i));
	task automatic cmp(input logic [7:0] got, input logic [7:0] want);
		n_tests++;
		if (got !== want)
		begin
			failures++;
			$display("[ERR] %0t got %h want %h", $time, got, want);
		end
	endtask : cmp
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task automatic wr(input logic [2:0] we, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		{dir_we_i, out_we_i, dien_we_i} = we;
		wdata_i = d;
		@(posedge clk_i);
		#1;
		{dir_we_i, out_we_i, dien_we_i} = 3'h0;
	endtask : wr
	// note the per-pin expectation, let pins and config settle, flag the watcher
	task automatic note();
		e = '{(dir & outv) | (~dir & den & drv) | (~dir & ~den), dir, dir & outv, den};
		repeat (4) @(posedge clk_i);
		#1;
		q.push_back(e);
		chk = 1'h1;
		@(posedge clk_i);
		#1;
		chk = 1'h0;
	endtask : note
	// watcher: oldest note against the settled outputs
	always @(negedge clk_i)
		if (chk)
		begin
			g = q.pop_front();
			cmp(cpd, g.view);
			cmp(pil, g.view);
			cmp(pov, g.view);
			cmp(pin_oe_o, g.oe);
			cmp(pin_o & pin_oe_o, g.drv);
			cmp(pdir, g.oe);
			cmp(pden, g.den);
			cmp(buf_en_o, g.den);
		end
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			stop_test();
		end
	end
	// random per-pin mixes, every fourth one written by all strobes at once
	initial
	begin
		void'($urandom(89906));
		{dir, outv, den} = '0;
		repeat (6) @(posedge clk_i);
		#1;
		nrst_i = 1'h1;
		note();
		for (int i = 0; i < 24; i++)
		begin
			dir = (i == 1) ? 8'hFF : $urandom();
			outv = $urandom();
			den = (i == 0) ? 8'hFF : $urandom();
			drv = $urandom();
			drv_en = ~dir;
			if (i % 4 == 0)
			begin
				{outv, den} = {dir, dir};
				wr(3'h7, dir);
			end
			else
			begin
				wr(3'h4, dir);
				wr(3'h2, outv);
				wr(3'h1, den);
			end
			note();
		end
		stop_test();
	end
endmodule : analog_pin_digital_port_test

//--- test/ext_circuit.sv
// far-side digital circuits sharing the pins
// assumes the port's drive wins wherever its enable is high
`timescale 1ns/1ps
module ext_circuit (
	input wire logic clk_i, // clock
	input wire logic [7:0] pin_o, // port drive
	input wire logic [7:0] pin_oe_o, // port drive on
	input wire logic [7:0] drv_i, // our level
	input wire logic [7:0] drv_en_i, // our drive on
	output logic [7:0] level_o // wire level
);
	logic [7:0] float_r = 8'h00;
	// a released wire wanders so a stale level cannot pass
	always @(posedge clk_i)
		float_r <= ~float_r;
	// wire level from both parties
	assign level_o = (pin_oe_o & pin_o) | (~pin_oe_o & ((drv_en_i & drv_i) | (~drv_en_i & float_r)));
endmodule : ext_circuit

//--- test/port_chk.sv
// checker on the ports of the analog-pin digital port
// assumes config outputs settle two edges after a strobe, pins three
`timescale 1ns/1ps
module port_chk #(
	parameter int PIN_COUNT = 8
) (
	input wire logic clk_i, // clock
	input wire logic nrst_i, // reset
	input wire logic dir_we_i, // strobe
	input wire logic out_we_i, // strobe
	input wire logic dien_we_i, // strobe
	input wire logic [PIN_COUNT-1:0] wdata_i, // data
	input wire logic [PIN_COUNT-1:0] pin_i, // pins
	input wire logic [PIN_COUNT-1:0] pin_o, // drive
	input wire logic [PIN_COUNT-1:0] pin_oe_o, // drive on
	input wire logic [PIN_COUNT-1:0] buf_en_o, // buffer
	input wire logic [PIN_COUNT-1:0] converter_port_data_o, // view
	input wire logic [PIN_COUNT-1:0] port_output_value_o, // view
	input wire logic [PIN_COUNT-1:0] port_input_level_o, // view
	input wire logic [PIN_COUNT-1:0] port_direction_o, // readback
	input wire logic [PIN_COUNT-1:0] digital_input_enable_o // readback
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	// enabled digital inputs, the only pins whose level is visible
	wire logic [PIN_COUNT-1:0] en_in = digital_input_enable_o & ~port_direction_o;
	a_dir_write: assert property (dir_we_i |-> ##2 port_direction_o == $past(wdata_i, 2))
		else $error("direction readback wrong");
	a_dien_write: assert property (dien_we_i |-> ##2 digital_input_enable_o == $past(wdata_i, 2))
		else $error("enable readback wrong");
	a_out_drive: assert property (out_we_i |-> ##2 ((pin_o ^ $past(wdata_i, 2)) & pin_oe_o) == '0)
		else $error("driven level wrong");
	a_oe_dir: assert property (pin_oe_o == port_direction_o)
		else $error("drive enable wrong");
	a_buf_gate: assert property (buf_en_o == digital_input_enable_o)
		else $error("buffer enable wrong");
	a_level_equal: assert property (((converter_port_data_o ^ port_input_level_o) & en_in) == '0)
		else $error("level views differ");
	a_off_one: assert property ((~(port_direction_o | digital_input_enable_o) & ~port_output_value_o) == '0)
		else $error("disabled input not one");
	a_pin_follow: assert property ((!dir_we_i && !dien_we_i)[*4] |-> ((port_output_value_o ^ $past(pin_i, 3)) & en_in) == '0)
		else $error("input view lost pin level");
endmodule : port_chk
bind analog_pin_digital_port port_chk #(.PIN_COUNT(PIN_COUNT)) port_chk_inst (.*);
